// ==== rtl/cdt_pkg.sv ====
// shared constants and types for the coprocessor transfer sequencer
package cdt_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] FIRST_PC_OFS = 32'h0000_0008;
    localparam logic [ADDR_W-1:0] RESUME_PC_OFS = 32'h0000_000c;
    localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        CDT_SIZE_BYTE = 2'h0,
        CDT_SIZE_HALF = 2'h1,
        CDT_SIZE_WORD = 2'h2
    } cdt_size_t;

    typedef enum {
        CDT_P_IDLE,
        CDT_P_FIRST,
        CDT_P_WAIT,
        CDT_P_XFER
    } cdt_proc_state_t;

    typedef enum {
        CDT_C_IDLE,
        CDT_C_XFER
    } cdt_cop_state_t;
endpackage

// ==== rtl/cdt_link_if.sv ====
// link between the processor sequencer and the attached coprocessor
`timescale 1ns/100ps
interface cdt_link_if;
    import cdt_pkg::*;
    logic [ADDR_W-1:0] addr;
    cdt_size_t access_size;
    logic write_not_read;
    logic mem_request_n;
    logic sequential_flag;
    logic opcode_fetch_n;
    logic coproc_instr_strobe_n;
    logic coproc_absent;
    logic coproc_busy;
    // memory read data, driven by the memory model outside
    logic [DATA_W-1:0] mem_rdata;
    // coprocessor store data toward memory
    logic [DATA_W-1:0] coproc_data_word;

    modport proc (
        output addr,
        output access_size,
        output write_not_read,
        output mem_request_n,
        output sequential_flag,
        output opcode_fetch_n,
        output coproc_instr_strobe_n,
        input coproc_absent,
        input coproc_busy
    );

    modport cop (
        input write_not_read,
        input coproc_instr_strobe_n,
        input mem_rdata,
        output coproc_absent,
        output coproc_busy,
        output coproc_data_word
    );
endinterface

// ==== rtl/cdt_cop.sv ====
// coprocessor end: commits, counts words, moves data
`timescale 1ns/100ps
module cdt_cop
    import cdt_pkg::*;
#(
    parameter int CNT_W = 8
)(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // link
    cdt_link_if.cop link,
    // user side
    input wire logic known_i,
    input wire logic ready_i,
    input wire logic dir_store_i,
    input wire logic [CNT_W-1:0] words_i,
    input wire logic [cdt_pkg::DATA_W-1:0] store_data_i,
    output logic store_take_o,
    output logic [cdt_pkg::DATA_W-1:0] load_word_o,
    output logic load_valid_o
);
    import cdt_pkg::*;

    // wider counts buy nothing and lengthen the decrement path
    if (CNT_W < 1 || CNT_W > 16)
    begin : g_cnt_w_check
        $error("cdt_cop: CNT_W out of range");
    end

    cdt_cop_state_t state_q;
    logic [CNT_W-1:0] left_q;
    logic [DATA_W-1:0] data_q;
    logic commit;
    logic last;

    assign commit = (state_q == CDT_C_IDLE) && !link.coproc_instr_strobe_n
        && known_i && ready_i;
    assign last = (state_q == CDT_C_XFER) && (left_q <= CNT_W'(1));

    always_comb
    begin
        if (state_q == CDT_C_XFER)
        begin
            // both high on final cycle only
            link.coproc_absent = last;
            link.coproc_busy = last;
        end
        else if (!link.coproc_instr_strobe_n && !known_i)
        begin
            link.coproc_absent = 1'b1;
            link.coproc_busy = 1'b1;
        end
        else if (!link.coproc_instr_strobe_n)
        begin
            link.coproc_absent = 1'b0;
            link.coproc_busy = !ready_i;
        end
        else
        begin
            link.coproc_absent = 1'b1;
            link.coproc_busy = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state_q <= CDT_C_IDLE;
        else if (ce_i)
        begin
            if (commit)
                state_q <= CDT_C_XFER;
            else if (last)
                state_q <= CDT_C_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            left_q <= '0;
        else if (ce_i)
        begin
            if (commit)
                left_q <= words_i;
            else if (state_q == CDT_C_XFER)
                left_q <= left_q - CNT_W'(1);
        end
    end

    // next store word is fetched one cycle ahead of its memory cycle
    assign store_take_o = ce_i && dir_store_i
        && (commit || ((state_q == CDT_C_XFER) && !last));

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            data_q <= DATA_RST;
        else if (store_take_o)
            data_q <= store_data_i;
    end
    assign link.coproc_data_word = data_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            load_word_o <= DATA_RST;
            load_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            load_valid_o <= (state_q == CDT_C_XFER) && !link.write_not_read;
            if ((state_q == CDT_C_XFER) && !link.write_not_read)
                load_word_o <= link.mem_rdata;
        end
    end
endmodule

// ==== rtl/cdt_proc.sv ====
// processor end: sequences coprocessor load and store transfers
`timescale 1ns/100ps

module cdt_proc
    import cdt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // link
    cdt_link_if.proc link,
    // instruction issue
    input wire logic start_i,
    input wire logic store_i,
    input wire logic compressed_i,
    input wire logic [cdt_pkg::ADDR_W-1:0] instr_pc_i,
    input wire logic [cdt_pkg::ADDR_W-1:0] base_i,
    // status
    output logic busy_o,
    output logic done_o,
    output logic refused_o,
    output logic undef_trap_o,
    // base write back
    output logic base_wb_valid_o,
    output logic [cdt_pkg::ADDR_W-1:0] base_wb_o
);
    import cdt_pkg::*;

    cdt_proc_state_t state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] pc_q;
    logic [ADDR_W-1:0] base_q;
    logic store_q;
    logic opc_n_q;
    logic strobe_n_q;
    logic wnr_q;
    logic in_decide;
    logic in_xfer;
    logic cp_trap;
    logic cp_go;
    logic cp_last;
    logic take;

    function automatic logic both_high(input logic absent,
                                       input logic busy);
        both_high = absent && busy;
    endfunction

    assign in_decide = (state_q == CDT_P_FIRST) || (state_q == CDT_P_WAIT);
    assign in_xfer = (state_q == CDT_P_XFER);
    // trap when coprocessor cannot do it
    assign cp_trap = in_decide
        && both_high(link.coproc_absent, link.coproc_busy);
    // enter the transfer only on busy low
    assign cp_go = in_decide && !link.coproc_busy;
    assign cp_last = in_xfer
        && both_high(link.coproc_absent, link.coproc_busy);
    assign take = (state_q == CDT_P_IDLE) && start_i && !compressed_i;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state_q <= CDT_P_IDLE;
        else if (ce_i)
        begin
            case (state_q)
                CDT_P_IDLE:
                begin
                    if (take)
                        state_q <= CDT_P_FIRST;
                end
                CDT_P_FIRST, CDT_P_WAIT:
                begin
                    if (cp_trap)
                        state_q <= CDT_P_IDLE;
                    else if (cp_go)
                        state_q <= CDT_P_XFER;
                    else
                        state_q <= CDT_P_WAIT;
                end
                CDT_P_XFER:
                begin
                    if (cp_last)
                        state_q <= CDT_P_IDLE;
                end
                default:
                    state_q <= CDT_P_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_q <= ADDR_RST;
            base_q <= ADDR_RST;
            store_q <= 1'b0;
        end
        else if (ce_i && take)
        begin
            pc_q <= instr_pc_i;
            base_q <= base_i;
            store_q <= store_i;
        end
    end

    // address bus
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            addr_q <= ADDR_RST;
        else if (ce_i)
        begin
            if (take)
                addr_q <= instr_pc_i + FIRST_PC_OFS;
            else if (cp_go)
                addr_q <= base_q;
            else if (cp_trap || cp_last)
                addr_q <= pc_q + RESUME_PC_OFS;
            else if (in_xfer)
                addr_q <= addr_q + WORD_STEP;
        end
    end

    // registered cycle-type lines, set one edge ahead of their cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            opc_n_q <= 1'b0;
            strobe_n_q <= 1'b1;
            wnr_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (take)
            begin
                opc_n_q <= 1'b0;
                strobe_n_q <= 1'b0;
                wnr_q <= 1'b0;
            end
            else if (cp_go)
            begin
                opc_n_q <= 1'b1;
                strobe_n_q <= 1'b1;
                wnr_q <= store_q;
            end
            else if (cp_trap || cp_last)
            begin
                opc_n_q <= 1'b0;
                strobe_n_q <= 1'b1;
                wnr_q <= 1'b0;
            end
            else if (state_q == CDT_P_FIRST)
            begin
                opc_n_q <= 1'b1;
                strobe_n_q <= 1'b0;
            end
        end
    end

    assign link.addr = addr_q;
    assign link.opcode_fetch_n = opc_n_q;
    assign link.coproc_instr_strobe_n = strobe_n_q;
    assign link.write_not_read = wnr_q;
    assign link.access_size = CDT_SIZE_WORD;

    // request and sequential follow the handshake in the same cycle
    always_comb
    begin
        if (in_decide)
        begin
            // request drops only as busy falls
            link.mem_request_n = link.coproc_busy;
            link.sequential_flag = 1'b0;
        end
        else if (in_xfer)
        begin
            link.mem_request_n = 1'b0;
            link.sequential_flag = !cp_last;
        end
        else
        begin
            link.mem_request_n = 1'b0;
            link.sequential_flag = 1'b0;
        end
    end

    // base write back each transfer cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            base_wb_valid_o <= 1'b0;
            base_wb_o <= ADDR_RST;
        end
        else if (ce_i)
        begin
            base_wb_valid_o <= in_xfer;
            if (in_xfer)
                base_wb_o <= addr_q + WORD_STEP;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            done_o <= 1'b0;
            refused_o <= 1'b0;
            undef_trap_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= cp_last;
            refused_o <= (state_q == CDT_P_IDLE) && start_i && compressed_i;
            undef_trap_o <= cp_trap;
        end
    end

    assign busy_o = (state_q != CDT_P_IDLE);
endmodule

// ==== tb/cdt_monitor.sv ====
// link assertions for the coprocessor transfer sequencer
`timescale 1ns/100ps
module cdt_monitor
    import cdt_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // link
    input wire logic [cdt_pkg::ADDR_W-1:0] addr,
    input wire cdt_pkg::cdt_size_t access_size,
    input wire logic write_not_read,
    input wire logic mem_request_n,
    input wire logic sequential_flag,
    input wire logic opcode_fetch_n,
    input wire logic coproc_instr_strobe_n,
    input wire logic coproc_absent,
    input wire logic coproc_busy
);
    logic xfer;
    logic last;
    logic dec;
    assign xfer = coproc_instr_strobe_n && opcode_fetch_n;
    assign last = coproc_absent && coproc_busy;
    assign dec = !coproc_instr_strobe_n;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_size_word: assert property (access_size == CDT_SIZE_WORD)
        else $error("access size not word");
    chk_wait_req: assert property (
        dec |-> mem_request_n == coproc_busy && !write_not_read)
        else $error("request wrong while deciding");
    chk_wait_hold: assert property (
        dec && $past(dec) |-> opcode_fetch_n && $stable(addr))
        else $error("busy wait cycle not held");
    chk_commit_xfer: assert property (
        dec && !coproc_busy |=> xfer && !mem_request_n)
        else $error("no transfer after commit");
    chk_trap_exit: assert property (
        dec && last |=> !xfer && !opcode_fetch_n && coproc_instr_strobe_n
            && addr == $past(addr) + 32'h4)
        else $error("trap exit wrong");
    chk_xfer_step: assert property (
        xfer && !last |=> xfer && addr == $past(addr) + 32'h4)
        else $error("transfer address not stepped");
    chk_seq_flag: assert property (
        xfer |-> sequential_flag == !last && !mem_request_n)
        else $error("sequential flag wrong");
    chk_last_resume: assert property (
        xfer && last |=> !opcode_fetch_n && !write_not_read)
        else $error("no fetch after last transfer");
    chk_wnr_steady: assert property (
        xfer && $past(xfer) |-> $stable(write_not_read))
        else $error("write line changed in transfer");
endmodule

// ==== tb/coproc_mem_transfer_seq_test.sv ====
// self-checking bench for the coprocessor transfer sequencer
`timescale 1ns/100ps
module coproc_mem_transfer_seq_test;
    import cdt_pkg::*;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic start = 1'h0;
    logic store = 1'h0;
    logic cmp = 1'h0;
    logic ce = 1'h1;
    logic known = 1'h1;
    logic ready = 1'h0;
    logic [7:0] words = 8'h01;
    logic [ADDR_W-1:0] pc = ADDR_RST;
    logic [ADDR_W-1:0] base = ADDR_RST;
    logic [DATA_W-1:0] sd = DATA_RST;
    logic busy, done, refused, trap, wb_valid, take, ld_valid;
    logic [ADDR_W-1:0] wb;
    logic [DATA_W-1:0] ld_word;
    int errors = 0;
    int comparisons = 0;

    cdt_link_if lnk();
    always #2 ref_clk = ~ref_clk;
    // memory pattern keyed to the address
    assign lnk.mem_rdata = lnk.addr ^ 32'h5a5a_0000;
    always @(posedge ref_clk)
        if (take === 1'h1)
            sd <= sd + 32'h1;

    cdt_proc cdt_proc_inst (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .ce_i(ce), .link(lnk), .start_i(start), .store_i(store),
        .compressed_i(cmp), .instr_pc_i(pc), .base_i(base),
        .busy_o(busy), .done_o(done), .refused_o(refused),
        .undef_trap_o(trap), .base_wb_valid_o(wb_valid), .base_wb_o(wb));
    cdt_cop cdt_cop_inst (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .ce_i(ce), .link(lnk), .known_i(known), .ready_i(ready),
        .dir_store_i(store), .words_i(words), .store_data_i(sd),
        .store_take_o(take), .load_word_o(ld_word),
        .load_valid_o(ld_valid));
    cdt_monitor cdt_monitor_inst (.ref_clk_i(ref_clk),
        .reset_n_i(reset_n), .addr(lnk.addr),
        .access_size(lnk.access_size),
        .write_not_read(lnk.write_not_read),
        .mem_request_n(lnk.mem_request_n),
        .sequential_flag(lnk.sequential_flag),
        .opcode_fetch_n(lnk.opcode_fetch_n),
        .coproc_instr_strobe_n(lnk.coproc_instr_strobe_n),
        .coproc_absent(lnk.coproc_absent),
        .coproc_busy(lnk.coproc_busy));

    task check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one instruction: w busy cycles, n words asked of the coprocessor
    task go(input logic st, cm, kn, input logic [31:0] p, b,
        input int w, n);
        int t;
        int k;
        int nw;
        int nl;
        logic fin;
        logic [31:0] a;
        logic [31:0] s0;
        begin
            t = 0;
            k = 0;
            nw = 0;
            nl = 0;
            fin = 1'h0;
            a = b;
            @(posedge ref_clk) #1;
            s0 = sd;
            store = st;
            cmp = cm;
            known = kn;
            pc = p;
            base = b;
            words = n[7:0];
            start = 1'h1;
            while (!fin && t < 100)
            begin
                @(posedge ref_clk) #1;
                start = 1'h0;
                t++;
                ready = (t > w);
                @(negedge ref_clk);
                if (t == 1)
                    check(busy, !cm);
                if (t == 1 && !cm)
                    check(lnk.addr, p + FIRST_PC_OFS);
                if (wb_valid === 1'h1)
                begin
                    check(wb, a);
                    nw++;
                end
                if (ld_valid === 1'h1)
                begin
                    check(ld_word, (a - 32'h4) ^ 32'h5a5a_0000);
                    nl++;
                end
                if (lnk.coproc_instr_strobe_n && lnk.opcode_fetch_n)
                begin
                    check(lnk.addr, a);
                    check(lnk.write_not_read, st);
                    if (st)
                        check(lnk.coproc_data_word, s0 + k);
                    a = a + WORD_STEP;
                    k++;
                end
                fin = (done | trap | refused) === 1'h1;
            end
            if (!fin)
            begin
                check(1'h0, 1'h1);
                test_done;
            end
            check({done, trap, refused}, {kn & !cm, !kn & !cm, cm});
            check(k, (kn && !cm) ? ((n == 0) ? 1 : n) : 0);
            check(nw, k);
            check(nl, st ? 0 : k);
            check(busy, 1'h0);
            if (!cm)
                check(lnk.addr, p + RESUME_PC_OFS);
        end
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1 reset_n = 1'h1;
        go(1'h0, 1'h0, 1'h1, 32'h1000, 32'h4000, 0, 1);
        go(1'h0, 1'h0, 1'h1, 32'h1100, 32'h4100, 2, 4);
        go(1'h1, 1'h0, 1'h1, 32'h1200, 32'h4200, 0, 3);
        go(1'h1, 1'h0, 1'h1, 32'h1300, 32'h4300, 3, 1);
        go(1'h0, 1'h0, 1'h1, 32'h1400, 32'h4400, 1, 0);
        go(1'h0, 1'h0, 1'h0, 32'h1500, 32'h4500, 1, 2);
        go(1'h1, 1'h1, 1'h1, 32'h1600, 32'h4600, 0, 2);
        go(1'h0, 1'h0, 1'h1, 32'h1700, 32'h4700, 0, 8);
        // reset in mid transfer, then a clean run
        // a frozen clock enable must hold off a pending start
        @(posedge ref_clk) #1;
        ce = 1'h0;
        start = 1'h1;
        repeat (3) @(posedge ref_clk);
        #1 check(busy, 1'h0);
        check(lnk.addr, 32'h1700 + RESUME_PC_OFS);
        ce = 1'h1;
        @(posedge ref_clk) #1;
        start = 1'h0;
        check(busy, 1'h1);
        repeat (3) @(posedge ref_clk);
        #1 reset_n = 1'h0;
        @(posedge ref_clk) #1;
        check(lnk.coproc_instr_strobe_n, 1'h1);
        reset_n = 1'h1;
        go(1'h1, 1'h0, 1'h1, 32'h1800, 32'h4800, 1, 2);
        test_done;
    end
endmodule
